// file: src/lpc_call_timing.sv
module lpc_call_timing
  import lpc_pkg::*;
#(
  parameter int NCH    = 2,
  parameter int MS_CYC = MS_TICK_CYC
)(
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic [NCH-1:0]        loop_occupied,
  input  wire logic [NCH-1:0]        loop_fault,
  input  wire logic [NCH-1:0]        phase_green_pin,
  input  wire logic [NCH-1:0][7:0]   dll_value,
  output logic      [NCH-1:0]        call_out,
  output logic      [NCH-1:0]        osc_enable,
  output logic      [NCH-1:0][3:0]   sens_level,
  output logic      [NCH-1:0][2:0]   freq_sel,
  output logic      [NCH-1:0]        chan_reset,
  output logic      [NCH-1:0]        tune_out,
  output logic      [NCH-1:0]        fast_recover,
  output logic      [1:0]            disp_on,
  output logic      [NCH-1:0][7:0]   dll_peak
);

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // ****************************************
  // Time base
  // ****************************************
  localparam int DIV_W = $clog2(MS_CYC + 1);

  logic [DIV_W-1:0] ms_div;
  logic [6:0]       tenth_div;
  logic             ms_tick;
  logic             tenth_tick;
  wire              ms_wrap    = ms_div == DIV_W'(MS_CYC - 1);
  wire              tenth_wrap = tenth_div == 7'(TENTH_MS - 1);

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ms_div     <= '0;
      tenth_div  <= '0;
      ms_tick    <= 1'b0;
      tenth_tick <= 1'b0;
    end
    else
    begin
      ms_div     <= ms_wrap ? '0 : ms_div + DIV_W'(1);
      ms_tick    <= ms_wrap;
      tenth_tick <= ms_tick && tenth_wrap;
      if (ms_tick)
        tenth_div <= tenth_wrap ? '0 : tenth_div + 7'd1;
    end
  end

  function automatic logic [TMR_W-1:0] to_tenths(input logic [9:0] secs);
    to_tenths = TMR_W'(secs) * TMR_W'(SEC_TENTHS);
  endfunction

  // ****************************************
  // Display options, shared by both channels
  // ****************************************
  logic [1:0][TMR_W-1:0] disp_tmr;
  wire                   wr_opt = reg_wr && reg_addr == ADDR_OPT;

  for (genvar d = 0; d < 2; d++)
  begin : g_disp
    // Bit 0 inductance, bit 1 change display; power loss is a reset
    always_ff @(posedge clk_sys or posedge reset)
    begin
      if (reset)
      begin
        disp_on[d]  <= 1'b0;
        disp_tmr[d] <= '0;
      end
      else if (wr_opt)
      begin
        disp_on[d]  <= reg_wdata[d];
        disp_tmr[d] <= TMR_W'(DISP_TENTHS);
      end
      else if (tenth_tick && disp_on[d])
      begin
        disp_tmr[d] <= disp_tmr[d] - TMR_W'(1);
        if (disp_tmr[d] == TMR_W'(1))
          disp_on[d] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  logic [NCH-1:0]            pulse_mode;
  logic [NCH-1:0]            ext_ctl;
  logic [NCH-1:0]            eog_bit;
  logic [NCH-1:0][7:0]       dly;
  logic [NCH-1:0][7:0]       ext;
  logic [NCH-1:0][9:0]       maxp;
  logic [NCH-1:0]            gs1;
  logic [NCH-1:0]            gs2;
  logic [NCH-1:0]            gs3;
  logic [NCH-1:0]            green;
  logic [NCH-1:0]            green_d;
  lpc_state_t                st [NCH];
  lpc_state_t                next_st [NCH];
  logic [NCH-1:0][TMR_W-1:0] tmr;
  logic [NCH-1:0][TMR_W-1:0] next_tmr;
  logic [NCH-1:0][TMR_W-1:0] mp;
  logic [NCH-1:0][TMR_W-1:0] next_mp;
  logic [NCH-1:0][6:0]       pc;
  logic [NCH-1:0][6:0]       next_pc;
  logic [NCH-1:0][2:0]       rc;
  logic [NCH-1:0][2:0]       next_rc;
  logic [NCH-1:0][4:0]       hold;
  logic [NCH-1:0]            blk;
  logic [NCH-1:0]            next_blk;
  logic [NCH-1:0]            rst_ev;
  logic [NCH-1:0]            tune_ev;
  logic [NCH-1:0][31:0]      rd_ch;
  logic [NCH*8-1:0]          stat_bits;
  logic [NCH*8-1:0]          peak_bits;

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    wire [7:0] ch_base  = 8'(g) * ADDR_CH_STRIDE;
    wire       hit_cfg  = reg_addr == ch_base + OFS_CFG;
    wire       hit_dly  = reg_addr == ch_base + OFS_DLY;
    wire       hit_ext  = reg_addr == ch_base + OFS_EXT;
    wire       hit_maxp = reg_addr == ch_base + OFS_MAXP;

    wire f_call   = sens_level[g] == SENS_CALL;
    wire f_off    = sens_level[g] >= SENS_OFF;
    wire forced   = f_call || f_off;
    wire occ      = loop_occupied[g];
    wire mp_on    = maxp[g] != 10'h000;
    wire eog_eff  = eog_bit[g] && mp_on;
    wire ext_ok   = ext[g] != 8'h00 && (!ext_ctl[g] || green[g]);
    wire g_fall   = green_d[g] && !green[g];
    wire presence = next_st[g] == ST_DETECT || next_st[g] == ST_EXTEND || next_st[g] == ST_WAIT;
    wire next_call = f_call || (!f_off && (pulse_mode[g] ? next_pc[g] != 7'h00 : presence));

    assign rd_ch[g] = hit_cfg  ? 32'({eog_bit[g], ext_ctl[g], pulse_mode[g], freq_sel[g], sens_level[g]}) :
                      hit_dly  ? 32'(dly[g]) :
                      hit_ext  ? 32'(ext[g]) :
                      hit_maxp ? 32'(maxp[g]) : 32'h0000_0000;
    assign stat_bits[g*8 +: 8] = {loop_fault[g], call_out[g], st[g]};
    assign peak_bits[g*8 +: 8] = dll_peak[g];

    always_ff @(posedge clk_sys or posedge reset)
    begin
      if (reset)
      begin
        sens_level[g] <= RST_SENS;
        freq_sel[g]   <= RST_FREQ;
        pulse_mode[g] <= 1'b0;
        ext_ctl[g]    <= 1'b0;
        eog_bit[g]    <= 1'b0;
        dly[g]        <= 8'h00;
        ext[g]        <= 8'h00;
        maxp[g]       <= 10'h000;
      end
      else if (reg_wr)
      begin
        if (hit_cfg)
        begin
          sens_level[g] <= reg_wdata[CFG_SENS_LSB +: 4];
          freq_sel[g]   <= reg_wdata[CFG_FREQ_LSB +: 3];
          pulse_mode[g] <= reg_wdata[CFG_PULSE_BIT];
          ext_ctl[g]    <= reg_wdata[CFG_EXTCTL_BIT];
          eog_bit[g]    <= reg_wdata[CFG_EOG_BIT];
        end
        if (hit_dly)
          dly[g] <= reg_wdata[7:0];
        if (hit_ext)
          ext[g] <= reg_wdata[7:0];
        if (hit_maxp)
          maxp[g] <= reg_wdata[9:0];
      end
    end

    // Phase green is a pin; a change counts once two late stages agree
    always_ff @(posedge clk_sys or posedge reset)
    begin
      if (reset)
      begin
        gs1[g]     <= 1'b0;
        gs2[g]     <= 1'b0;
        gs3[g]     <= 1'b0;
        green[g]   <= 1'b0;
        green_d[g] <= 1'b0;
      end
      else
      begin
        gs1[g]     <= phase_green_pin[g];
        gs2[g]     <= gs1[g];
        gs3[g]     <= gs2[g];
        green_d[g] <= green[g];
        if (gs2[g] == gs3[g])
          green[g] <= gs3[g];
      end
    end

    always_comb
    begin
      next_st[g]  = st[g];
      next_tmr[g] = (tenth_tick && tmr[g] != '0) ? tmr[g] - TMR_W'(1) : tmr[g];
      next_mp[g]  = mp[g];
      next_pc[g]  = (ms_tick && pc[g] != 7'h00) ? pc[g] - 7'd1 : pc[g];
      next_rc[g]  = (tenth_tick && rc[g] != 3'h0) ? rc[g] - 3'd1 : rc[g];
      // Blocking holds off re-detection until a retuned loop reads empty
      next_blk[g] = blk[g] && occ;
      rst_ev[g]   = 1'b0;
      tune_ev[g]  = 1'b0;
      if (forced)
        next_st[g] = ST_IDLE;
      else
      begin
        case (st[g])
          ST_IDLE:
            if (occ && !blk[g])
            begin
              if (pulse_mode[g])
              begin
                next_st[g]  = ST_PULSE;
                next_tmr[g] = TMR_W'(TUNE_TENTHS);
                next_pc[g]  = 7'(PULSE_MS);
              end
              else if (dly[g] == 8'h00 || green[g])
              begin
                next_st[g] = ST_DETECT;
                next_mp[g] = to_tenths(maxp[g]);
              end
              else
              begin
                next_st[g]  = ST_DELAY;
                next_tmr[g] = to_tenths(10'(dly[g]));
              end
            end
            // A tuned-out vehicle leaving must also get the recovery window
            else if (!occ && blk[g] && pulse_mode[g])
              next_rc[g] = 3'(RECOV_TENTHS);
          ST_DELAY:
            if (!occ)
              next_st[g] = ST_IDLE;
            else if (green[g] || tmr[g] == '0)
            begin
              next_st[g] = ST_DETECT;
              next_mp[g] = to_tenths(maxp[g]);
            end
          ST_DETECT:
          begin
            if (tenth_tick && mp[g] != '0)
              next_mp[g] = mp[g] - TMR_W'(1);
            if (mp_on && mp[g] == '0)
            begin
              if (eog_eff)
                next_st[g] = ST_WAIT;
              else
                rst_ev[g] = 1'b1;
            end
            else if (!occ)
            begin
              if (ext_ok)
              begin
                next_st[g]  = ST_EXTEND;
                next_tmr[g] = TMR_W'(ext[g]);
              end
              else
                next_st[g] = ST_IDLE;
            end
            // Otherwise the call stays for as long as the zone is held
          end
          ST_EXTEND:
            if (occ)
              next_st[g] = ST_DETECT;
            else if (tmr[g] == '0)
              next_st[g] = ST_IDLE;
          ST_WAIT:
            if (!occ)
              next_st[g] = ST_IDLE;
            else if (g_fall && !loop_fault[g])
              rst_ev[g] = 1'b1;
          ST_PULSE:
            if (!occ)
            begin
              next_st[g] = ST_IDLE;
              next_rc[g] = 3'(RECOV_TENTHS);
            end
            else if (tmr[g] == '0)
            begin
              tune_ev[g]  = 1'b1;
              next_blk[g] = 1'b1;
              next_st[g]  = ST_IDLE;
            end
          default:
            next_st[g] = ST_IDLE;
        endcase
        if (rst_ev[g])
        begin
          next_st[g]  = ST_IDLE;
          next_blk[g] = 1'b1;
        end
      end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
      if (reset)
      begin
        st[g]           <= ST_IDLE;
        tmr[g]          <= '0;
        mp[g]           <= '0;
        pc[g]           <= 7'h00;
        rc[g]           <= 3'h0;
        blk[g]          <= 1'b0;
        call_out[g]     <= 1'b0;
        osc_enable[g]   <= 1'b0;
        chan_reset[g]   <= 1'b0;
        tune_out[g]     <= 1'b0;
        fast_recover[g] <= 1'b0;
      end
      else
      begin
        st[g]           <= next_st[g];
        tmr[g]          <= next_tmr[g];
        mp[g]           <= next_mp[g];
        pc[g]           <= next_pc[g];
        rc[g]           <= next_rc[g];
        blk[g]          <= next_blk[g];
        call_out[g]     <= next_call;
        osc_enable[g]   <= !forced;
        chan_reset[g]   <= rst_ev[g];
        tune_out[g]     <= tune_ev[g];
        fast_recover[g] <= next_rc[g] != 3'h0;
      end
    end

    // Peak is refreshed by a larger value or once the hold has run out
    always_ff @(posedge clk_sys or posedge reset)
    begin
      if (reset)
      begin
        dll_peak[g] <= 8'h00;
        hold[g]     <= 5'h00;
      end
      else if (disp_on[1] && call_out[g])
      begin
        if (dll_value[g] > dll_peak[g] || hold[g] == 5'h00)
        begin
          dll_peak[g] <= dll_value[g];
          hold[g]     <= 5'(PEAK_TENTHS);
        end
        else if (tenth_tick)
          hold[g] <= hold[g] - 5'd1;
      end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_forced_call: assert property (f_call |=> call_out[g] && !osc_enable[g])
      else $error("forced call not held");
    a_forced_off: assert property (f_off |=> !call_out[g] && !osc_enable[g])
      else $error("off setting not held");
    a_green_abort: assert property (st[g] == ST_DELAY && green[g] && occ && !forced
      |=> st[g] == ST_DETECT)
      else $error("green did not abort delay");
    a_ext_restart: assert property (st[g] == ST_EXTEND && occ && !forced
      |=> st[g] == ST_DETECT && call_out[g])
      else $error("entry during extension not detected");
    a_pulse_width: assert property ($rose(pc[g] != 7'h00) && !forced
      |-> call_out[g] [*8])
      else $error("pulse call dropped early");
    a_maxp_reset: assert property (st[g] == ST_DETECT && mp_on && mp[g] == '0 && !eog_eff && !forced
      |=> chan_reset[g] && st[g] == ST_IDLE ##1 !call_out[g])
      else $error("max presence reset missing");
    a_wait_enter: assert property (st[g] == ST_DETECT && mp_on && mp[g] == '0 && eog_eff && !forced
      |=> st[g] == ST_WAIT && !chan_reset[g])
      else $error("wait state not entered");
    a_fail_hold: assert property (st[g] == ST_WAIT && loop_fault[g] && occ && !forced
      |=> st[g] == ST_WAIT && !chan_reset[g])
      else $error("failed loop reset at end of green");
    c_delay_done: cover property (st[g] == ST_DELAY ##1 st[g] == ST_DETECT);
    c_wait_reset: cover property (st[g] == ST_WAIT ##1 chan_reset[g]);
    c_tune_out: cover property (tune_out[g]);
  end

  // ****************************************
  // Register read
  // ****************************************
  logic [31:0] rd_any;
  wire  [31:0] rd_glob = (reg_addr == ADDR_OPT)  ? 32'(disp_on) :
                         (reg_addr == ADDR_STAT) ? 32'(stat_bits) :
                         (reg_addr == ADDR_PEAK) ? 32'(peak_bits) : 32'h0000_0000;

  always_comb
  begin
    rd_any = rd_glob;
    for (int i = 0; i < NCH; i++)
      rd_any = rd_any | rd_ch[i];
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_rd ? rd_any : 32'h0000_0000;
  end

endmodule

// file: src/lpc_pkg.sv
package lpc_pkg;

  // ****************************************
  // Time base
  // ****************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS         = 1000000;
  localparam int MS_TICK_CYC   = MS_NS / CLK_PERIOD_NS;
  localparam int TENTH_MS      = 100;
  localparam int SEC_TENTHS    = 1000 / TENTH_MS;
  localparam int PULSE_MS      = 125;
  localparam int TUNE_OUT_MS   = 2000;
  localparam int TUNE_TENTHS   = TUNE_OUT_MS / TENTH_MS;
  localparam int RECOV_MS      = 500;
  localparam int RECOV_TENTHS  = RECOV_MS / TENTH_MS;
  localparam int PEAK_HOLD_MS  = 2000;
  localparam int PEAK_TENTHS   = PEAK_HOLD_MS / TENTH_MS;
  localparam int DISP_OFF_MIN  = 15;
  localparam int DISP_TENTHS   = DISP_OFF_MIN * 60000 / TENTH_MS;
  localparam int TMR_W         = 14;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h10;
  localparam logic [7:0] OFS_CFG        = 8'h00;
  localparam logic [7:0] OFS_DLY        = 8'h04;
  localparam logic [7:0] OFS_EXT        = 8'h08;
  localparam logic [7:0] OFS_MAXP       = 8'h0c;
  localparam logic [7:0] ADDR_OPT       = 8'h20;
  localparam logic [7:0] ADDR_STAT      = 8'h24;
  localparam logic [7:0] ADDR_PEAK      = 8'h28;

  localparam int CFG_SENS_LSB   = 0;
  localparam int CFG_FREQ_LSB   = 4;
  localparam int CFG_PULSE_BIT  = 7;
  localparam int CFG_EXTCTL_BIT = 8;
  localparam int CFG_EOG_BIT    = 9;

  localparam logic [3:0] SENS_CALL = 4'h9;
  localparam logic [3:0] SENS_OFF  = 4'ha;
  localparam logic [3:0] RST_SENS  = 4'h4;
  localparam logic [2:0] RST_FREQ  = 3'h0;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_DELAY  = 6'h02,
    ST_DETECT = 6'h04,
    ST_EXTEND = 6'h08,
    ST_WAIT   = 6'h10,
    ST_PULSE  = 6'h20
  } lpc_state_t;

endpackage

// file: testbench/lpc_ctrl_model.sv
// ****************************************
// Signal controller seen from the detector
// ****************************************
module lpc_ctrl_model
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [1:0]  call_out,
  input  wire logic [1:0]  green_cmd,
  output logic      [1:0]  phase_green_pin,
  output logic      [15:0] call_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] call_q;
  wire        call_rise = call_out[0] & ~call_q[0];

  // Green follows the phase plan one cycle late; calls on channel 0 are counted by rising edge
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      phase_green_pin <= 2'h0;
      call_q          <= 2'h0;
      call_cnt        <= 16'h0;
    end
    else
    begin
      phase_green_pin <= green_cmd;
      call_q          <= call_out;
      if (call_rise)
        call_cnt <= call_cnt + 16'h1;
    end
  end
endmodule

// file: testbench/test_loop_channel_call_timing.sv
module test_loop_channel_call_timing
  import lpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // One tenth tick is 400 cycles, one second 4000 cycles
  localparam int MSC = 4;
  localparam int TEN = MSC * 100;
  localparam int SEC = TEN * 10;
  logic            clk_sys = 1'b0;
  logic            reset   = 1'b1;
  logic [7:0]      reg_addr = 8'h0;
  logic [31:0]     reg_wdata = 32'h0;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [31:0]     reg_rdata;
  logic [1:0]      loop_occupied = 2'h0;
  logic [1:0]      loop_fault = 2'h0;
  logic [1:0]      green_cmd = 2'h0;
  logic [1:0]      phase_green_pin;
  logic [1:0][7:0] dll_value = '0;
  logic [1:0]      call_out, osc_enable, chan_reset, tune_out, fast_recover, disp_on;
  logic [1:0][3:0] sens_level;
  logic [1:0][2:0] freq_sel;
  logic [1:0][7:0] dll_peak;
  logic [15:0]     call_cnt;
  int              error_cnt = 0;
  int              n_checks = 0;
  int              n_rst = 0;
  int              n_tune = 0;
  int              r0, n;
  logic [31:0]     d;

  always #2.5 clk_sys = ~clk_sys;

  lpc_call_timing #(.NCH(2), .MS_CYC(MSC)) uut (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .loop_occupied(loop_occupied), .loop_fault(loop_fault),
    .phase_green_pin(phase_green_pin), .dll_value(dll_value), .call_out(call_out), .osc_enable(osc_enable),
    .sens_level(sens_level), .freq_sel(freq_sel), .chan_reset(chan_reset), .tune_out(tune_out),
    .fast_recover(fast_recover), .disp_on(disp_on), .dll_peak(dll_peak));

  lpc_ctrl_model ctrl (
    .clk_sys(clk_sys), .reset(reset), .call_out(call_out), .green_cmd(green_cmd),
    .phase_green_pin(phase_green_pin), .call_cnt(call_cnt));

  // Pulse outputs stand one cycle, so they are tallied on every edge
  always @(posedge clk_sys)
  begin
    if (chan_reset[0] === 1'b1) n_rst <= n_rst + 1;
    if (tune_out[0] === 1'b1) n_tune <= n_tune + 1;
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask

  task automatic run(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask

  task automatic wait_call(input logic v, input int maxc, output int cnt);
    cnt = 0;
    while (call_out[0] !== v && cnt < maxc)
    begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end
  endtask

  task automatic occ(input logic v);
    @(posedge clk_sys);
    loop_occupied[0] <= v;
  endtask

  task automatic setup(input logic [3:0] s, input logic p, input logic x, input logic e, input int dl, input int ex,
                       input int mp);
    wr(OFS_CFG, (32'(s) << CFG_SENS_LSB) | (32'(p) << CFG_PULSE_BIT) | (32'(x) << CFG_EXTCTL_BIT) |
       (32'(e) << CFG_EOG_BIT));
    wr(OFS_DLY, 32'(dl));
    wr(OFS_EXT, 32'(ex));
    wr(OFS_MAXP, 32'(mp));
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #(5ns * 90000);
    error_cnt++;
    tally_and_finish();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    run(2);
    chk("sens_rst", sens_level[0], RST_SENS);
    rd(OFS_CFG, d);
    chk("cfg_rst", d, 32'h4);
    rd(8'h30, d);
    chk("unmapped", d, 32'h0);
    for (int s = 0; s < 11; s++)
    begin
      wr(ADDR_CH_STRIDE, 32'(s) | (32'(s % 8) << CFG_FREQ_LSB));
      run(2);
      chk("sens_sel", sens_level[1], 32'(s));
      chk("freq_sel", freq_sel[1], 32'(s % 8));
      chk("osc_en", osc_enable[1], s < 9);
      chk("forced_call", call_out[1], s == 9);
    end
    setup(SENS_OFF, 0, 0, 0, 0, 0, 0);
    occ(1);
    run(20);
    chk("off_call", call_out[0], 0);
    occ(0);
    setup(4'h3, 0, 0, 0, 1, 0, 0);
    occ(1);
    wait_call(1, 2 * SEC, n);
    chk("delay_ok", n >= SEC - TEN && n <= SEC + TEN, 1);
    occ(0);
    wait_call(0, 20, n);
    wr(OFS_DLY, 32'h2);
    occ(1);
    run(200);
    chk("delay_hold", call_out[0], 0);
    green_cmd[0] <= 1'b1;
    wait_call(1, 20, n);
    chk("green_abort", call_out[0], 1);
    green_cmd[0] <= 1'b0;
    occ(0);
    setup(4'h3, 0, 0, 0, 0, 5, 0);
    occ(1);
    run(6000);
    chk("presence_hold", call_out[0], 1);
    rd(ADDR_STAT, d);
    chk("stat_detect", d[7:0], 8'h44);
    occ(0);
    run(1200);
    occ(1);
    run(100);
    occ(0);
    run(1500);
    chk("ext_restart", call_out[0], 1);
    wait_call(0, 1200, n);
    chk("ext_end", call_out[0], 0);
    wr(OFS_CFG, 32'h3 | (32'h1 << CFG_EXTCTL_BIT));
    occ(1);
    run(50);
    occ(0);
    wait_call(0, 40, n);
    chk("extctl_nogreen", call_out[0], 0);
    setup(4'h3, 1, 0, 0, 3, 5, 1);
    r0 = int'(call_cnt);
    occ(1);
    wait_call(1, 20, n);
    wait_call(0, 800, n);
    chk("pulse_len", n >= 460 && n <= 540, 1);
    r0 = n_tune;
    run(2 * SEC - 1300);
    chk("no_early_tune", n_tune, r0);
    run(1300);
    chk("tune_once", n_tune, r0 + 1);
    occ(0);
    run(5);
    chk("recover_on", fast_recover[0], 1);
    run(2400);
    chk("recover_off", fast_recover[0], 0);
    r0 = int'(call_cnt);
    occ(1);
    run(1000);
    occ(0);
    run(10);
    chk("one_pulse", int'(call_cnt), r0 + 1);
    setup(4'h3, 0, 0, 0, 0, 0, 1);
    occ(1);
    run(2000);
    occ(0);
    r0 = n_rst;
    run(3000);
    chk("early_empty", n_rst, r0);
    chk("early_drop", call_out[0], 0);
    occ(1);
    run(SEC - 500);
    chk("maxp_running", n_rst, r0);
    run(1000);
    chk("maxp_reset", n_rst, r0 + 1);
    occ(0);
    run(10);
    for (int f = 0; f < 2; f++)
    begin
      wr(OFS_CFG, 32'h3 | (32'h1 << CFG_EOG_BIT));
      loop_fault[0] <= f[0];
      green_cmd[0]  <= 1'b1;
      occ(1);
      r0 = n_rst;
      run(SEC + 600);
      chk("wait_no_reset", n_rst, r0);
      rd(ADDR_STAT, d);
      chk("stat_wait", d[6:0], 7'h50);
      green_cmd[0] <= 1'b0;
      run(20);
      chk("eog_reset", n_rst, r0 + 1 - f);
      occ(0);
      loop_fault[0] <= 1'b0;
      run(10);
    end
    wr(OFS_MAXP, 32'h0);
    wr(ADDR_OPT, 32'h3);
    run(2);
    chk("disp_on", disp_on, 2'h3);
    occ(1);
    dll_value[0] <= 8'h50;
    repeat (20) @(posedge clk_sys);
    dll_value[0] <= 8'h10;
    run(SEC);
    chk("peak_hold", dll_peak[0], 8'h50);
    run(2 * SEC);
    chk("peak_follow", dll_peak[0], 8'h10);
    occ(0);
    run(10);
    tally_and_finish();
  end
endmodule
